// file: logic/agr_pkg.sv
package agr_pkg;

  // ---------------------------------------------------------------
  // bus widths and register offsets
  // ---------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 8;
  localparam logic [7:0] OFS_ROUTE = 8'h18;
  localparam logic [7:0] OFS_BIAS = 8'h19;
  localparam logic [7:0] OFS_AGC_A = 8'h1A;
  localparam logic [7:0] OFS_AGC_B = 8'h1B;
  localparam logic [7:0] OFS_AGC_C = 8'h1C;

  // ---------------------------------------------------------------
  // reset values, writable masks, unmapped answer
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ROUTE = 8'h78;
  localparam logic [7:0] RST_BIAS = 8'h00;
  localparam logic [7:0] RST_AGC_A = 8'h00;
  localparam logic [7:0] RST_AGC_B = 8'hFE;
  localparam logic [7:0] RST_AGC_C = 8'h00;
  localparam logic [7:0] MSK_ROUTE = 8'hF8;
  localparam logic [7:0] MSK_BIAS = 8'hC0;
  localparam logic [7:0] MSK_AGC_A = 8'hFF;
  localparam logic [7:0] MSK_AGC_B = 8'hFF;
  localparam logic [7:0] MSK_AGC_C = 8'hC0;
  localparam logic [7:0] RD_NONE = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DIFF_BIT = 7;
  localparam int LVL_MSB = 6;
  localparam int LVL_LSB = 3;
  localparam int BIAS_MSB = 7;
  localparam int BIAS_LSB = 6;
  localparam int EN_BIT = 7;
  localparam int TGT_MSB = 6;
  localparam int TGT_LSB = 4;
  localparam int ATK_MSB = 3;
  localparam int ATK_LSB = 2;
  localparam int DCY_MSB = 1;
  localparam int DCY_LSB = 0;
  localparam int MAX_MSB = 7;
  localparam int MAX_LSB = 1;
  localparam int HYS_MSB = 7;
  localparam int HYS_LSB = 6;

  // ---------------------------------------------------------------
  // field codes and decoded values
  // ---------------------------------------------------------------
  localparam logic [3:0] LVL_LAST_GAIN = 4'h8;
  localparam logic [3:0] LVL_OFF = 4'hF;
  localparam logic [1:0] HYS_OFF = 2'h3;
  localparam logic [6:0] MAX_GAIN_CAP = 7'h77;
  localparam logic [7:0] GAIN_IDLE = 8'h00;
  localparam int TIME_W = 10;
  localparam logic [9:0] ATK_MS_0 = 10'h008;
  localparam logic [9:0] ATK_MS_1 = 10'h00B;
  localparam logic [9:0] ATK_MS_2 = 10'h010;
  localparam logic [9:0] ATK_MS_3 = 10'h014;
  localparam logic [9:0] DCY_MS_0 = 10'h064;
  localparam logic [9:0] DCY_MS_1 = 10'h0C8;
  localparam logic [9:0] DCY_MS_2 = 10'h190;
  localparam logic [9:0] DCY_MS_3 = 10'h1F4;

  typedef enum logic [1:0] {
    BIAS_OFF = 2'h0,
    BIAS_2V0 = 2'h1,
    BIAS_2V5 = 2'h2,
    BIAS_SUPPLY = 2'h3
  } agr_bias_t;

endpackage : agr_pkg

// file: logic/agr_time_decode.sv
// attack and decay codes to nominal milliseconds
module agr_time_decode (
  input wire logic [1:0] attack_code,
  input wire logic [1:0] decay_code,
  input wire logic double_rate,
  output logic [agr_pkg::TIME_W-1:0] attack_ms,
  output logic [agr_pkg::TIME_W-1:0] decay_ms,
  output logic times_exact
);

  // ---------------------------------------------------------------
  // lookup of nominal time constants
  // ---------------------------------------------------------------
  assign attack_ms = (attack_code == 2'h0) ? agr_pkg::ATK_MS_0 :
                     (attack_code == 2'h1) ? agr_pkg::ATK_MS_1 :
                     (attack_code == 2'h2) ? agr_pkg::ATK_MS_2 :
                     agr_pkg::ATK_MS_3;
  assign decay_ms = (decay_code == 2'h0) ? agr_pkg::DCY_MS_0 :
                    (decay_code == 2'h1) ? agr_pkg::DCY_MS_1 :
                    (decay_code == 2'h2) ? agr_pkg::DCY_MS_2 :
                    agr_pkg::DCY_MS_3;
  // nominal figures hold only outside double-rate mode
  assign times_exact = ~double_rate;

endmodule : agr_time_decode

// file: logic/agr_gain_clamp.sv
// caps the requested loop gain at the programmed maximum
module agr_gain_clamp (
  input wire logic enable,
  input wire logic [6:0] max_code,
  input wire logic [7:0] gain_req,
  output logic [6:0] max_eff,
  output logic [7:0] gain_out
);

  // ---------------------------------------------------------------
  // saturate max code, then clamp signed request
  // ---------------------------------------------------------------
  logic over_cap;
  logic over_max;
  logic [7:0] clamped;

  // codes above the cap all mean the top step
  assign over_cap = (max_code > agr_pkg::MAX_GAIN_CAP);
  assign max_eff = over_cap ? agr_pkg::MAX_GAIN_CAP : max_code;
  assign over_max = ($signed(gain_req) > $signed({1'b0, max_eff}));
  assign clamped = over_max ? {1'b0, max_eff} : gain_req;
  assign gain_out = enable ? clamped : agr_pkg::GAIN_IDLE;

endmodule : agr_gain_clamp

// file: logic/agr_regs.sv
// Functional notes
// - routing bit 7 picks single-ended plus pin or differential plus/minus pair
// - level codes 0000..1000 give 0 to -12 dB and connect to mixer
// - level code 1111, the reset value, leaves the input disconnected
// - routing bits 2..0 and bias bits 5..0 read only, read zero
// - bias field selects off, 2 V, 2.5 V or analog supply; resets off
// - AGC A bit 7 enables the left gain loop; resets disabled
// - three-bit target field selects -5.5 down to -24 dB target
// - attack field selects 8, 11, 16 or 20 ms
// - decay field selects 100, 200, 400 or 500 ms
// - listed times valid only while double-rate mode is off
// - max-gain field caps in 0.5 dB steps, codes above 59 dB give 59.5
// - hysteresis field gives 1, 2, 3 dB or disabled for 11
module agr_regs (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [agr_pkg::AW-1:0] ADDR,
  input wire logic [agr_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [agr_pkg::DW-1:0] RDATA,
  input wire logic DOUBLE_RATE_AUDIO_MODE,
  input wire logic [7:0] AGC_GAIN_REQ,
  output logic LEFT_IN_DIFF,
  output logic LEFT_IN_MIX_EN,
  output logic [3:0] LEFT_IN_LEVEL,
  output logic [1:0] MIC_BIAS_LEVEL,
  output logic AGC_EN,
  output logic [2:0] AGC_TARGET,
  output logic [agr_pkg::TIME_W-1:0] AGC_ATTACK_MS,
  output logic [agr_pkg::TIME_W-1:0] AGC_DECAY_MS,
  output logic AGC_TIMES_EXACT,
  output logic [6:0] AGC_MAX_GAIN,
  output logic [7:0] AGC_GAIN,
  output logic AGC_HYST_EN,
  output logic [1:0] AGC_HYST_LEVEL
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] route_r;
  logic [7:0] bias_r;
  logic [7:0] agc_a_r;
  logic [7:0] agc_b_r;
  logic [7:0] agc_c_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic hit_route;
  logic hit_bias;
  logic hit_agc_a;
  logic hit_agc_b;
  logic hit_agc_c;
  logic wr_route;
  logic wr_bias;
  logic wr_agc_a;
  logic wr_agc_b;
  logic wr_agc_c;

  // one hit per mapped offset
  assign hit_route = (ADDR == agr_pkg::OFS_ROUTE);
  assign hit_bias = (ADDR == agr_pkg::OFS_BIAS);
  assign hit_agc_a = (ADDR == agr_pkg::OFS_AGC_A);
  assign hit_agc_b = (ADDR == agr_pkg::OFS_AGC_B);
  assign hit_agc_c = (ADDR == agr_pkg::OFS_AGC_C);

  // write strobes qualified per register
  assign wr_route = WR & hit_route;
  assign wr_bias = WR & hit_bias;
  assign wr_agc_a = WR & hit_agc_a;
  assign wr_agc_b = WR & hit_agc_b;
  assign wr_agc_c = WR & hit_agc_c;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // read-only bits are masked away on every write
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      route_r <= agr_pkg::RST_ROUTE;
      bias_r <= agr_pkg::RST_BIAS;
      agc_a_r <= agr_pkg::RST_AGC_A;
      agc_b_r <= agr_pkg::RST_AGC_B;
      agc_c_r <= agr_pkg::RST_AGC_C;
    end else begin
      if (wr_route) begin
        route_r <= WDATA & agr_pkg::MSK_ROUTE;
      end
      if (wr_bias) begin
        bias_r <= WDATA & agr_pkg::MSK_BIAS;
      end
      if (wr_agc_a) begin
        agc_a_r <= WDATA & agr_pkg::MSK_AGC_A;
      end
      if (wr_agc_b) begin
        agc_b_r <= WDATA & agr_pkg::MSK_AGC_B;
      end
      if (wr_agc_c) begin
        agc_c_r <= WDATA & agr_pkg::MSK_AGC_C;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // unmapped offsets and idle cycles answer zero
  assign rdata_nxt = !RD ? agr_pkg::RD_NONE :
                     hit_route ? route_r :
                     hit_bias ? bias_r :
                     hit_agc_a ? agc_a_r :
                     hit_agc_b ? agc_b_r :
                     hit_agc_c ? agc_c_r :
                     agr_pkg::RD_NONE;

  // read data valid in the cycle after the strobe
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= agr_pkg::RD_NONE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  logic [3:0] lvl_code;
  logic mix_conn;
  logic [1:0] atk_code;
  logic [1:0] dcy_code;
  logic [1:0] hys_code;
  logic [9:0] atk_ms;
  logic [9:0] dcy_ms;
  logic times_ok;
  logic [6:0] max_eff;
  logic [7:0] gain_cl;

  assign lvl_code = route_r[agr_pkg::LVL_MSB:agr_pkg::LVL_LSB];
  // reserved codes are treated as not connected
  assign mix_conn = (lvl_code <= agr_pkg::LVL_LAST_GAIN);
  assign atk_code = agc_a_r[agr_pkg::ATK_MSB:agr_pkg::ATK_LSB];
  assign dcy_code = agc_a_r[agr_pkg::DCY_MSB:agr_pkg::DCY_LSB];
  assign hys_code = agc_c_r[agr_pkg::HYS_MSB:agr_pkg::HYS_LSB];

  // ---------------------------------------------------------------
  // decoders
  // ---------------------------------------------------------------
  agr_time_decode u_time (
    .attack_code(atk_code),
    .decay_code(dcy_code),
    .double_rate(DOUBLE_RATE_AUDIO_MODE),
    .attack_ms(atk_ms),
    .decay_ms(dcy_ms),
    .times_exact(times_ok)
  );

  agr_gain_clamp u_clamp (
    .enable(agc_a_r[agr_pkg::EN_BIT]),
    .max_code(agc_b_r[agr_pkg::MAX_MSB:agr_pkg::MAX_LSB]),
    .gain_req(AGC_GAIN_REQ),
    .max_eff(max_eff),
    .gain_out(gain_cl)
  );

  // ---------------------------------------------------------------
  // registered control outputs
  // ---------------------------------------------------------------
  // each output follows its register, or the double-rate or gain request input, one edge later
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LEFT_IN_DIFF <= 1'b0;
      LEFT_IN_MIX_EN <= 1'b0;
      LEFT_IN_LEVEL <= agr_pkg::LVL_OFF;
      MIC_BIAS_LEVEL <= agr_pkg::BIAS_OFF;
      AGC_EN <= 1'b0;
      AGC_TARGET <= 3'h0;
      AGC_ATTACK_MS <= agr_pkg::ATK_MS_0;
      AGC_DECAY_MS <= agr_pkg::DCY_MS_0;
      AGC_TIMES_EXACT <= 1'b0;
      AGC_MAX_GAIN <= agr_pkg::MAX_GAIN_CAP;
      AGC_GAIN <= agr_pkg::GAIN_IDLE;
      AGC_HYST_EN <= 1'b0;
      AGC_HYST_LEVEL <= 2'h0;
    end else begin
      LEFT_IN_DIFF <= route_r[agr_pkg::DIFF_BIT];
      LEFT_IN_MIX_EN <= mix_conn;
      LEFT_IN_LEVEL <= lvl_code;
      MIC_BIAS_LEVEL <= bias_r[agr_pkg::BIAS_MSB:agr_pkg::BIAS_LSB];
      AGC_EN <= agc_a_r[agr_pkg::EN_BIT];
      AGC_TARGET <= agc_a_r[agr_pkg::TGT_MSB:agr_pkg::TGT_LSB];
      AGC_ATTACK_MS <= atk_ms;
      AGC_DECAY_MS <= dcy_ms;
      AGC_TIMES_EXACT <= times_ok;
      AGC_MAX_GAIN <= max_eff;
      AGC_GAIN <= gain_cl;
      AGC_HYST_EN <= (hys_code != agr_pkg::HYS_OFF);
      AGC_HYST_LEVEL <= hys_code;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_diff_follows;
    wr_route |=> ##1 (LEFT_IN_DIFF == $past(WDATA[agr_pkg::DIFF_BIT], 2));
  endproperty
  a_diff_follows: assert property (p_diff_follows)
    else $error("input mode output does not follow write");

  property p_gain_code_connects;
    (wr_route && (WDATA[agr_pkg::LVL_MSB:agr_pkg::LVL_LSB] <= agr_pkg::LVL_LAST_GAIN))
      |=> ##1 LEFT_IN_MIX_EN;
  endproperty
  a_gain_code_connects: assert property (p_gain_code_connects)
    else $error("gain code did not connect the input");

  property p_off_code_disconnects;
    (LEFT_IN_LEVEL == agr_pkg::LVL_OFF) |-> !LEFT_IN_MIX_EN;
  endproperty
  a_off_code_disconnects: assert property (p_off_code_disconnects)
    else $error("off code left the input connected");

  property p_level_follows;
    wr_route |=> ##1 (LEFT_IN_LEVEL == $past(WDATA[agr_pkg::LVL_MSB:agr_pkg::LVL_LSB], 2));
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("level code does not follow write");

  property p_off_write_disconnects;
    (wr_route && (WDATA[agr_pkg::LVL_MSB:agr_pkg::LVL_LSB] == agr_pkg::LVL_OFF))
      |=> ##1 !LEFT_IN_MIX_EN;
  endproperty
  a_off_write_disconnects: assert property (p_off_write_disconnects)
    else $error("off code write did not disconnect the input");

  property p_route_rsv_masked;
    wr_route |=> (route_r[agr_pkg::LVL_LSB-1:0] == 3'h0);
  endproperty
  a_route_rsv_masked: assert property (p_route_rsv_masked)
    else $error("routing reserved bits stored nonzero");

  property p_bias_rsv_masked;
    wr_bias |=> (bias_r[agr_pkg::BIAS_LSB-1:0] == 6'h00);
  endproperty
  a_bias_rsv_masked: assert property (p_bias_rsv_masked)
    else $error("bias reserved bits stored nonzero");

  property p_route_rsv_zero;
    (RD && hit_route) |=> (RDATA[2:0] == 3'h0) && (RDATA[7:3] == $past(route_r[7:3]));
  endproperty
  a_route_rsv_zero: assert property (p_route_rsv_zero)
    else $error("routing reserved bits read nonzero");

  property p_bias_rsv_zero;
    (RD && hit_bias) |=> (RDATA[5:0] == 6'h00);
  endproperty
  a_bias_rsv_zero: assert property (p_bias_rsv_zero)
    else $error("bias reserved bits read nonzero");

  property p_bias_follows;
    wr_bias |=> ##1 (MIC_BIAS_LEVEL == $past(WDATA[agr_pkg::BIAS_MSB:agr_pkg::BIAS_LSB], 2));
  endproperty
  a_bias_follows: assert property (p_bias_follows)
    else $error("bias level does not follow write");

  property p_enable_follows;
    wr_agc_a |=> ##1 (AGC_EN == $past(WDATA[agr_pkg::EN_BIT], 2));
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("loop enable does not follow write");

  property p_target_follows;
    wr_agc_a |=> ##1 (AGC_TARGET == $past(WDATA[agr_pkg::TGT_MSB:agr_pkg::TGT_LSB], 2));
  endproperty
  a_target_follows: assert property (p_target_follows)
    else $error("target code does not follow write");

  property p_attack_fast;
    (atk_code == 2'h0) |=> (AGC_ATTACK_MS == agr_pkg::ATK_MS_0);
  endproperty
  a_attack_fast: assert property (p_attack_fast)
    else $error("attack code 00 not 8 ms");

  property p_decay_slow;
    (dcy_code == 2'h3) |=> (AGC_DECAY_MS == agr_pkg::DCY_MS_3);
  endproperty
  a_decay_slow: assert property (p_decay_slow)
    else $error("decay code 11 not 500 ms");

  property p_times_exact;
    NRST |=> (AGC_TIMES_EXACT == !$past(DOUBLE_RATE_AUDIO_MODE));
  endproperty
  a_times_exact: assert property (p_times_exact)
    else $error("time exact flag wrong for double-rate mode");

  property p_max_capped;
    (agc_b_r[agr_pkg::MAX_MSB:agr_pkg::MAX_LSB] > agr_pkg::MAX_GAIN_CAP)
      |=> (AGC_MAX_GAIN == agr_pkg::MAX_GAIN_CAP);
  endproperty
  a_max_capped: assert property (p_max_capped)
    else $error("max gain above top step");

  property p_hyst_off;
    (hys_code == agr_pkg::HYS_OFF) |=> !AGC_HYST_EN;
  endproperty
  a_hyst_off: assert property (p_hyst_off)
    else $error("hysteresis not disabled for code 11");

  property p_max_follows;
    (wr_agc_b && (WDATA[agr_pkg::MAX_MSB:agr_pkg::MAX_LSB] <= agr_pkg::MAX_GAIN_CAP))
      |=> ##1 (AGC_MAX_GAIN == $past(WDATA[agr_pkg::MAX_MSB:agr_pkg::MAX_LSB], 2));
  endproperty
  a_max_follows: assert property (p_max_follows)
    else $error("max gain does not follow write");

  property p_attack_slow;
    (wr_agc_a && (WDATA[agr_pkg::ATK_MSB:agr_pkg::ATK_LSB] == 2'h3))
      |=> ##1 (AGC_ATTACK_MS == agr_pkg::ATK_MS_3);
  endproperty
  a_attack_slow: assert property (p_attack_slow)
    else $error("attack code 11 not 20 ms");

  property p_hyst_level_follows;
    wr_agc_c |=> ##1 (AGC_HYST_LEVEL == $past(WDATA[agr_pkg::HYS_MSB:agr_pkg::HYS_LSB], 2));
  endproperty
  a_hyst_level_follows: assert property (p_hyst_level_follows)
    else $error("hysteresis code does not follow write");

  property p_gain_limit;
    AGC_EN |-> ($signed(AGC_GAIN) <= $signed({1'b0, AGC_MAX_GAIN}));
  endproperty
  a_gain_limit: assert property (p_gain_limit)
    else $error("applied gain exceeds maximum");

  property p_gain_idle;
    !AGC_EN |-> (AGC_GAIN == agr_pkg::GAIN_IDLE);
  endproperty
  a_gain_idle: assert property (p_gain_idle)
    else $error("gain nonzero while loop disabled");

endmodule : agr_regs

// file: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------
  logic clk;
  logic nrst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic dbl_rate;
  logic [7:0] gain_req;
  logic in_diff;
  logic in_mix_en;
  logic [3:0] in_level;
  logic [1:0] bias_level;
  logic agc_en;
  logic [2:0] agc_target;
  logic [9:0] attack_ms;
  logic [9:0] decay_ms;
  logic times_exact;
  logic [6:0] max_gain;
  logic [7:0] agc_gain;
  logic hyst_en;
  logic [1:0] hyst_level;
  int n_mismatch;
  int comparisons;
  logic [9:0] atk_tab [4] = '{10'h008, 10'h00B, 10'h010, 10'h014};
  logic [9:0] dcy_tab [4] = '{10'h064, 10'h0C8, 10'h190, 10'h1F4};

  agr_regs agr_regs_i (
    .CLK(clk),
    .NRST(nrst),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .DOUBLE_RATE_AUDIO_MODE(dbl_rate),
    .AGC_GAIN_REQ(gain_req),
    .LEFT_IN_DIFF(in_diff),
    .LEFT_IN_MIX_EN(in_mix_en),
    .LEFT_IN_LEVEL(in_level),
    .MIC_BIAS_LEVEL(bias_level),
    .AGC_EN(agc_en),
    .AGC_TARGET(agc_target),
    .AGC_ATTACK_MS(attack_ms),
    .AGC_DECAY_MS(decay_ms),
    .AGC_TIMES_EXACT(times_exact),
    .AGC_MAX_GAIN(max_gain),
    .AGC_GAIN(agc_gain),
    .AGC_HYST_EN(hyst_en),
    .AGC_HYST_LEVEL(hyst_level)
  );

  // 125 MHz clock
  always begin
    #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // one-cycle write, then let decoded outputs land
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr_reg

  // one-cycle read, data sampled in the following cycle only
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", 10'(rdata), 10'(exp));
  endtask : rd_chk

  // gain request sampled at one edge, answered after it
  task automatic gain_chk(input logic [7:0] r, input logic [7:0] exp);
    @(posedge clk);
    gain_req <= r;
    @(posedge clk);
    #1;
    check("agc_gain", 10'(agc_gain), 10'(exp));
  endtask : gain_chk

  task automatic reset_dut();
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
  endtask : reset_dut

  // reset state of every register and of the routing, bias, enable, max-gain and hysteresis outputs
  task automatic chk_reset();
    check("level", 10'(in_level), 10'h00F);
    check("mix_en", 10'(in_mix_en), 10'h000);
    check("diff", 10'(in_diff), 10'h000);
    check("bias", 10'(bias_level), 10'h000);
    check("agc_en", 10'(agc_en), 10'h000);
    check("max_gain", 10'(max_gain), 10'h077);
    check("hyst_en", 10'(hyst_en), 10'h001);
    check("hyst_level", 10'(hyst_level), 10'h000);
    rd_chk(8'h18, 8'h78);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h1A, 8'h00);
    rd_chk(8'h1B, 8'hFE);
    rd_chk(8'h1C, 8'h00);
  endtask : chk_reset

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] code;
    logic [6:0] mx;
    int i;
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    dbl_rate = 1'b0;
    gain_req = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    reset_dut();
    chk_reset();
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h1D, 8'h00);
    // routing: gain codes, off code, mode bit, reserved low bits
    for (i = 0; i < 10; i++) begin
      code = (i < 9) ? 4'(i) : 4'hF;
      wr_reg(8'h18, {i[0], code, 3'h0});
      check("diff", 10'(in_diff), 10'(i[0]));
      check("level", 10'(in_level), 10'(code));
      check("mix_en", 10'(in_mix_en), 10'(i < 9));
      rd_chk(8'h18, {i[0], code, 3'h0});
    end
    // bias level, reserved bits written and read as zero
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h19, {2'(i), 6'h00});
      check("bias", 10'(bias_level), 10'(i));
      rd_chk(8'h19, {2'(i), 6'h00});
    end
    // enable, every target, attack and decay code
    for (i = 0; i < 8; i++) begin
      wr_reg(8'h1A, {i[0], 3'(i), 2'(i), 2'(3 - i)});
      check("agc_en", 10'(agc_en), 10'(i[0]));
      check("target", 10'(agc_target), 10'(i));
      check("attack", attack_ms, atk_tab[i % 4]);
      check("decay", decay_ms, dcy_tab[2'(3 - i)]);
      rd_chk(8'h1A, {i[0], 3'(i), 2'(i), 2'(3 - i)});
    end
    // double-rate mode marks the listed times as inexact
    check("exact", 10'(times_exact), 10'h001);
    @(posedge clk);
    dbl_rate <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("exact", 10'(times_exact), 10'h000);
    @(posedge clk);
    dbl_rate <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("exact", 10'(times_exact), 10'h001);
    // max gain boundaries around the saturation point
    for (i = 0; i < 4; i++) begin
      mx = (i == 0) ? 7'h00 : (i == 1) ? 7'h76 : (i == 2) ? 7'h77 : 7'h7F;
      wr_reg(8'h1B, {mx, 1'b0});
      check("max_gain", 10'(max_gain), 10'((mx > 7'h76) ? 7'h77 : mx));
      rd_chk(8'h1B, {mx, 1'b0});
    end
    // clamp of the loop gain while enabled, zero while disabled
    wr_reg(8'h1B, 8'h40);
    wr_reg(8'h1A, 8'h80);
    gain_chk(8'h10, 8'h10);
    gain_chk(8'h20, 8'h20);
    gain_chk(8'h21, 8'h20);
    gain_chk(8'h7F, 8'h20);
    gain_chk(8'hE8, 8'hE8);
    wr_reg(8'h1A, 8'h00);
    gain_chk(8'h10, 8'h00);
    // hysteresis codes, disable at 11
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h1C, {2'(i), 6'h3F});
      check("hyst_level", 10'(hyst_level), 10'(i));
      check("hyst_en", 10'(hyst_en), 10'(i != 3));
      rd_chk(8'h1C, {2'(i), 6'h00});
    end
    // unmapped write leaves mapped registers alone
    wr_reg(8'h1D, 8'hFF);
    rd_chk(8'h1D, 8'h00);
    rd_chk(8'h1A, 8'h00);
    // two reads one idle cycle apart, then idle read data
    rd_chk(8'h1B, 8'h40);
    rd_chk(8'h19, 8'hC0);
    @(posedge clk);
    #1;
    check("rdata_idle", 10'(rdata), 10'h000);
    // second reset in mid-run
    wr_reg(8'h18, 8'h80);
    @(posedge clk);
    reset_dut();
    chk_reset();
    final_report();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

endmodule : tb_top
